/* rzs_contact_relay.sv */
// rzs_contact_relay: model of a site relay driving the two rear dry contacts
// assumes the bench sets closeZero/closeSpan off the clock edge; 1 = closed
`timescale 1ns/1ps
module rzs_contact_relay (
  // clock
  input wire logic ref_clk,
  // bench commands
  input wire logic closeZero,
  input wire logic closeSpan,
  // contact levels seen by the block
  output logic zeroRequestContact,
  output logic spanRequestContact
);
  // both open
  // contacts rest open (low) unless commanded, so the re-arm gap is kept by the bench
  always_ff @(posedge ref_clk) begin
    zeroRequestContact <= closeZero;
    spanRequestContact <= closeSpan;
  end
endmodule

/* rzs_hold_timer.sv */
// rzs_hold_timer: counts cycles while its condition holds, flags when the count is reached
// assumes cond is already synchronous to ref_clk
`timescale 1ns/1ps
module rzs_hold_timer #(
  parameter logic [24:0] Limit = 25'h0000001
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // condition and result
  input wire logic cond,
  output logic done
);
  logic [24:0] count_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= rzs_pkg::CntZero;
    end else if (!cond) begin
      count_reg <= rzs_pkg::CntZero;
    end else if (count_reg != Limit) begin
      count_reg <= count_reg + 25'h0000001;
    end
  end

  assign done = cond && (count_reg == Limit);
endmodule

/* rzs_pkg.sv */
// rzs_pkg: constants and types for the remote zero/span contact selector
// assumes a 20 MHz system clock; all times are derived from it
package rzs_pkg;
  localparam int unsigned ClkHz = 20000000;
  localparam int unsigned HoldTimeMs = 1000;
  localparam int unsigned HoldCycles = (ClkHz / 1000) * HoldTimeMs;
  localparam int unsigned BlankTimeMs = 1000;
  localparam int unsigned BlankCycles = (ClkHz / 1000) * BlankTimeMs;
  localparam int CntW = 25;
  localparam logic [24:0] CntZero = 25'h0000000;

  typedef enum logic [2:0] {
    RZS_ARMED = 3'b000,
    RZS_ZERO = 3'b001,
    RZS_SPAN = 3'b010,
    RZS_REARM = 3'b011,
    RZS_BLANK = 3'b100
  } rzs_state_t;

  // valve drive pair
  typedef struct packed {
    logic sampleCal;
    logic zeroSpan;
  } rzs_valve_t;

  // pulses at end of a remote valve cycle
  typedef struct packed {
    logic zeroCal;
    logic spanCal;
    logic checkDone;
  } rzs_calcmd_t;
endpackage

/* rzs_selector.sv */
// rzs_selector: remote contact zero/span mode selector, top level
// assumes contacts are dry closures (1 = closed) from outside the clock domain
`timescale 1ns/1ps
module rzs_selector #(
  // qualify and blank lengths in cycles; the defaults give one second each
  parameter logic [24:0] HoldLimit = 25'(rzs_pkg::HoldCycles),
  parameter logic [24:0] BlankLimit = 25'(rzs_pkg::BlankCycles)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // rear panel contacts, high when closed
  input wire logic zeroRequestContact,
  input wire logic spanRequestContact,
  // calibrate enables
  input wire logic zeroCalEnable,
  input wire logic spanCalEnable,
  // mode and valves
  output logic sampleMode,
  output logic zeroMode,
  output logic spanMode,
  output rzs_pkg::rzs_valve_t valves,
  // end of cycle commands and averaging gate
  output rzs_pkg::rzs_calcmd_t calCmd,
  output logic averagingExclude
);
  logic [1:0] zeroSync_reg;
  logic [1:0] spanSync_reg;
  logic zeroClosed;
  logic spanClosed;
  logic zeroHeld;
  logic spanHeld;
  logic bothHeld;
  logic openHeld;
  logic blankDone;
  rzs_pkg::rzs_state_t state_reg;
  rzs_pkg::rzs_state_t state_next;

  // two-flop synchronisers on the pins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      zeroSync_reg <= 2'h0;
      spanSync_reg <= 2'h0;
    end else begin
      zeroSync_reg <= {zeroSync_reg[0], zeroRequestContact};
      spanSync_reg <= {spanSync_reg[0], spanRequestContact};
    end
  end

  assign zeroClosed = zeroSync_reg[1];
  assign spanClosed = spanSync_reg[1];

  rzs_hold_timer #(.Limit(HoldLimit)) zeroHold (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cond(zeroClosed && !spanClosed),
    .done(zeroHeld)
  );
  rzs_hold_timer #(.Limit(HoldLimit)) spanHold (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cond(spanClosed && !zeroClosed),
    .done(spanHeld)
  );
  rzs_hold_timer #(.Limit(HoldLimit)) bothHold (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cond(spanClosed && zeroClosed),
    .done(bothHeld)
  );
  rzs_hold_timer #(.Limit(HoldLimit)) openHold (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cond(!spanClosed && !zeroClosed),
    .done(openHeld)
  );
  rzs_hold_timer #(.Limit(BlankLimit)) blankHold (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cond(state_reg == rzs_pkg::RZS_BLANK),
    .done(blankDone)
  );

  // mode sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      rzs_pkg::RZS_ARMED: begin
        // invalid pair needs a fresh re-arm
        if (bothHeld) begin
          state_next = rzs_pkg::RZS_REARM;
        end else if (zeroHeld) begin
          state_next = rzs_pkg::RZS_ZERO;
        end else if (spanHeld) begin
          state_next = rzs_pkg::RZS_SPAN;
        end
      end
      rzs_pkg::RZS_ZERO: begin
        if (!zeroClosed) begin
          state_next = (zeroCalEnable) ? rzs_pkg::RZS_BLANK : rzs_pkg::RZS_REARM;
        end
      end
      rzs_pkg::RZS_SPAN: begin
        if (!spanClosed) begin
          state_next = (spanCalEnable) ? rzs_pkg::RZS_BLANK : rzs_pkg::RZS_REARM;
        end
      end
      rzs_pkg::RZS_BLANK: begin
        if (blankDone) begin
          state_next = rzs_pkg::RZS_REARM;
        end
      end
      rzs_pkg::RZS_REARM: begin
        if (openHeld) begin
          state_next = rzs_pkg::RZS_ARMED;
        end
      end
      default: begin
        state_next = rzs_pkg::RZS_REARM;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= rzs_pkg::RZS_REARM;
    end else begin
      state_reg <= state_next;
    end
  end

  // registered mode and valve outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sampleMode <= 1'b1;
      zeroMode <= 1'b0;
      spanMode <= 1'b0;
      valves <= '0;
    end else begin
      // sample unless in a valve cycle
      sampleMode <= (state_next != rzs_pkg::RZS_ZERO) && (state_next != rzs_pkg::RZS_SPAN);
      zeroMode <= (state_next == rzs_pkg::RZS_ZERO);
      spanMode <= (state_next == rzs_pkg::RZS_SPAN);
      valves.sampleCal <= (state_next == rzs_pkg::RZS_ZERO) || (state_next == rzs_pkg::RZS_SPAN);
      valves.zeroSpan <= (state_next == rzs_pkg::RZS_SPAN);
    end
  end

  // end of cycle pulses and averaging gate
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      calCmd <= '0;
      averagingExclude <= 1'b0;
    end else begin
      calCmd.zeroCal <= (state_reg == rzs_pkg::RZS_ZERO) && !zeroClosed && zeroCalEnable;
      calCmd.spanCal <= (state_reg == rzs_pkg::RZS_SPAN) && !spanClosed && spanCalEnable;
      calCmd.checkDone <= ((state_reg == rzs_pkg::RZS_ZERO) && !zeroClosed)
        || ((state_reg == rzs_pkg::RZS_SPAN) && !spanClosed);
      averagingExclude <= (state_next == rzs_pkg::RZS_BLANK);
    end
  end

  // assertions
  property modeNeedsHold;
    @(posedge ref_clk) disable iff (!rstn)
      $rose(zeroMode) |-> $past(zeroHeld);
  endproperty
  zero_hold_a: assert property (modeNeedsHold) else $error("zero mode without hold");

  span_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(spanMode) |-> $past(spanHeld)) else $error("span mode without hold");

  mode_stays_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    zeroMode && zeroClosed |=> zeroMode) else $error("zero mode dropped while closed");

  rearm_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_reg == rzs_pkg::RZS_REARM && !openHeld |=> state_reg != rzs_pkg::RZS_ARMED)
    else $error("armed before open second");

  sample_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sampleMode |-> !zeroMode && !spanMode) else $error("sample overlaps cal mode");

  sequence spanEnd;
    state_reg == rzs_pkg::RZS_SPAN && !spanClosed && spanCalEnable;
  endsequence
  span_cal_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    spanEnd |=> calCmd.spanCal ##1 !calCmd.spanCal) else $error("span cal pulse wrong");

  zero_valve_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    zeroMode |-> valves.sampleCal && !valves.zeroSpan) else $error("zero valves wrong");

  cal_enable_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    calCmd.zeroCal |-> $past(zeroCalEnable)) else $error("zero cal without enable");

  blank_excl_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    calCmd.zeroCal |-> averagingExclude) else $error("no exclusion after cal");

  both_invalid_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_reg == rzs_pkg::RZS_ARMED && bothHeld |=> state_reg == rzs_pkg::RZS_REARM)
    else $error("both closed not rejected");
endmodule

/* testbench.sv */
// testbench: short, invalid and full valve-cycle checks of the remote zero/span selector
// assumes hold and blank are cut to a few cycles so that whole cycles fit the run
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic closeZero = 1'b0;
  logic closeSpan = 1'b0;
  logic zeroCalEnable = 1'b0;
  logic spanCalEnable = 1'b0;
  logic zeroRequestContact, spanRequestContact, sampleMode, zeroMode, spanMode;
  logic averagingExclude;
  rzs_pkg::rzs_valve_t valves;
  rzs_pkg::rzs_calcmd_t calCmd;
  int miscompares = 0;
  int numChecks = 0;
  // hold and blank cut down; the design keeps one second by default
  localparam int HoldT = 32'h64;
  localparam int BlankT = 32'h3c;
  // pin set to mode: relay, two sync flops, hold count, mode output register
  localparam int ModeDelay = HoldT + 32'h4;
  // pin open to end pulse: relay, two sync flops, output register
  localparam int EndDelay = 32'h4;

  always #25 ref_clk = ~ref_clk;

  rzs_contact_relay relay (.ref_clk(ref_clk), .closeZero(closeZero), .closeSpan(closeSpan),
    .zeroRequestContact(zeroRequestContact), .spanRequestContact(spanRequestContact));

  rzs_selector #(.HoldLimit(25'(HoldT)), .BlankLimit(25'(BlankT))) dut (.ref_clk(ref_clk),
    .rstn(rstn), .zeroRequestContact(zeroRequestContact),
    .spanRequestContact(spanRequestContact), .zeroCalEnable(zeroCalEnable),
    .spanCalEnable(spanCalEnable), .sampleMode(sampleMode), .zeroMode(zeroMode),
    .spanMode(spanMode), .valves(valves), .calCmd(calCmd),
    .averagingExclude(averagingExclude));

  task automatic cmp_vec(input logic [2:0] got, input logic [2:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp_num(input logic [31:0] got, input logic [31:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // every short or invalid closure must leave the block sampling with valves at rest
  task automatic check_idle();
    cmp_vec({2'h0, sampleMode}, 3'h1, "sampleMode");
    cmp_vec({1'b0, spanMode, zeroMode}, 3'h0, "span/zero mode");
    cmp_vec({1'b0, valves}, 3'h0, "valves");
    cmp_vec(calCmd, 3'h0, "calCmd");
    cmp_vec({2'h0, averagingExclude}, 3'h0, "averagingExclude");
  endtask

  // closes the contacts and counts edges until a mode shows; a hang runs out the bound
  task automatic wait_mode(input logic z, input logic s, output int n);
    @(posedge ref_clk);
    #2;
    closeZero = z;
    closeSpan = s;
    n = 0;
    while (n < 4 * HoldT && zeroMode !== 1'b1 && spanMode !== 1'b1) begin
      @(posedge ref_clk);
      #2;
      n++;
    end
  endtask

  task automatic hold_mode(input logic z, input logic s, input int n, input logic [2:0] modes);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #2;
      closeZero = z;
      closeSpan = s;
      cmp_vec({spanMode, zeroMode, sampleMode}, modes, "modes held");
    end
  endtask

  // opens both contacts and follows the end pulse, blanking and re-arm
  task automatic end_cycle(input logic [2:0] expCmd, input int expExcl);
    int pulses;
    int excl;
    pulses = 0;
    excl = 0;
    @(posedge ref_clk);
    #2;
    closeZero = 1'b0;
    closeSpan = 1'b0;
    for (int i = 1; i <= HoldT + 20; i++) begin
      @(posedge ref_clk);
      #2;
      if (i == EndDelay) begin
        cmp_vec(calCmd, expCmd, "cycle end command");
        cmp_vec({spanMode, zeroMode, sampleMode}, 3'h1, "sample after cycle");
      end
      if (calCmd !== 3'h0) begin
        pulses++;
      end
      if (averagingExclude === 1'b1) begin
        excl++;
      end
    end
    cmp_num(pulses, 1, "end pulse count");
    cmp_num(excl, expExcl, "exclusion cycles");
  endtask

  task automatic hold_contacts(input logic z, input logic s, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #2;
      closeZero = z;
      closeSpan = s;
      check_idle();
    end
  endtask

  // after reset both contacts must stay open for the hold before a request counts
  task automatic scen_reset();
    check_idle();
    hold_contacts(1'b1, 1'b0, 2 * HoldT);
    hold_contacts(1'b0, 1'b0, HoldT + 10);
  endtask

  task automatic scen_short_zero();
    zeroCalEnable = 1'b1;
    hold_contacts(1'b1, 1'b0, HoldT - 10);
    hold_contacts(1'b0, 1'b0, 200);
  endtask

  task automatic scen_short_span();
    spanCalEnable = 1'b1;
    hold_contacts(1'b0, 1'b1, HoldT - 10);
    hold_contacts(1'b0, 1'b0, 200);
  endtask

  task automatic scen_both_closed();
    hold_contacts(1'b1, 1'b1, 2 * HoldT);
    hold_contacts(1'b1, 1'b0, HoldT + 10);
    hold_contacts(1'b0, 1'b0, 200);
  endtask

  // closures that alternate faster than the hold never complete a qualification
  task automatic scen_chatter();
    zeroCalEnable = 1'b0;
    for (int k = 0; k < 20; k++) begin
      hold_contacts(1'b1, 1'b0, HoldT - 1);
      hold_contacts(1'b0, 1'b1, HoldT - 1);
    end
    hold_contacts(1'b0, 1'b0, 50);
  endtask

  // a closure of the other contact during a mode is ignored
  task automatic scen_zero_check();
    int n;
    zeroCalEnable = 1'b0;
    wait_mode(1'b1, 1'b0, n);
    cmp_num(n, ModeDelay, "zero mode delay");
    cmp_vec({spanMode, zeroMode, sampleMode}, 3'h2, "zero mode");
    cmp_vec({1'b0, valves}, 3'h2, "zero valves");
    hold_mode(1'b1, 1'b1, 20, 3'h2);
    hold_mode(1'b1, 1'b0, 20, 3'h2);
    end_cycle(3'h1, 0);
  endtask

  task automatic scen_zero_cal();
    int n;
    zeroCalEnable = 1'b1;
    wait_mode(1'b1, 1'b0, n);
    cmp_num(n, ModeDelay, "zero cal mode delay");
    end_cycle(3'h5, BlankT + 1);
  endtask

  task automatic scen_span_cal();
    int n;
    spanCalEnable = 1'b1;
    wait_mode(1'b0, 1'b1, n);
    cmp_num(n, ModeDelay, "span mode delay");
    cmp_vec({spanMode, zeroMode, sampleMode}, 3'h4, "span mode");
    cmp_vec({1'b0, valves}, 3'h3, "span valves");
    hold_mode(1'b0, 1'b1, 20, 3'h4);
    end_cycle(3'h3, BlankT + 1);
  endtask

  task automatic scen_span_check();
    int n;
    spanCalEnable = 1'b0;
    wait_mode(1'b0, 1'b1, n);
    cmp_num(n, ModeDelay, "span check delay");
    end_cycle(3'h1, 0);
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    #2;
    rstn = 1'b1;
    @(posedge ref_clk);
    #2;
    scen_reset();
    scen_short_zero();
    scen_short_span();
    scen_both_closed();
    scen_chatter();
    scen_zero_check();
    scen_zero_cal();
    scen_span_cal();
    scen_span_check();
    give_verdict();
  end
endmodule
